// ---- src/ssd_pkg.sv ----
// Constants and types shared by the seven-segment scan block
package ssd_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned REFRESH_US      = 4_000;
  localparam int unsigned REFRESH_MIN_US  = 1_000;
  localparam int unsigned REFRESH_MAX_US  = 16_000;
  localparam int unsigned NUM_DIGITS      = 4;
  localparam longint unsigned REFRESH_CYC = (longint'(CLK_HZ) * REFRESH_US) / 1_000_000;
  localparam int unsigned SLOT_CYC        = int'(REFRESH_CYC / NUM_DIGITS);

  // ---------------------------------------------------------------
  // Widths, reset values and the segment pattern for a one
  // ---------------------------------------------------------------
  localparam int unsigned SEG_W      = 7;
  localparam int unsigned SYNC_W     = 2;
  localparam logic [3:0]  SEL_OFF    = 4'hF;
  localparam logic [6:0]  SEG_OFF    = 7'h7F;
  localparam logic [6:0]  SEG_ONE_N  = 7'h79;

  typedef enum logic [0:0] {
    SSD_BLANK,
    SSD_SCAN
  } ssd_state_t;

endpackage : ssd_pkg

// ---- src/ssd_sync.sv ----
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module ssd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ssd_sync_state_t;

  ssd_sync_state_t state_r;
  ssd_sync_state_t state_nxt;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("ssd_sync: WIDTH must be at least 1");
    end
  endgenerate

  always_comb begin
    state_nxt        = state_r;
    state_nxt.meta   = async_in;
    state_nxt.stable = state_r.meta;
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stable;

endmodule : ssd_sync

// ---- src/ssd_scan_io.sv ----
// Scanning controller for a four-digit seven-segment display plus buttons, switches and LEDs
//
// Notes on behaviour
// - A user LED is lit by driving its output high and dark when low.
// - Digit selects, segment lines and decimal point are all active low.
// - Shared segment lines carry only the pattern of the one digit selected.
// - Each of the seven segments is controlled on its own, allowing all 128 patterns.
// - All four digits are visited once per refresh period of 4 x SLOT_CYC cycles, checked to be at most 16 ms.
// - Digits rotate continuously, each getting an equal quarter of the period.
// - The refresh rate stays well above 45 Hz to avoid flicker.
// - Segment outputs hold the digit's pattern for as long as its select is active.
// - A decimal one lights only segments B and C.
`timescale 1ns/10ps
module ssd_scan_io #(
  parameter int unsigned NUM_BUTTONS = 5,
  parameter int unsigned NUM_SWITCHES = 16,
  parameter int unsigned NUM_LEDS    = 16,
  parameter int unsigned SLOT_CYC    = ssd_pkg::SLOT_CYC
) (
  input  wire logic                    mclk_in,
  input  wire logic                    resetn_in,
  input  wire logic [NUM_BUTTONS-1:0]  button_in,
  input  wire logic [NUM_SWITCHES-1:0] switch_in,
  input  wire logic [NUM_LEDS-1:0]     led_level_in,
  input  wire logic [15:0]             hex_value_in,
  input  wire logic [3:0]              raw_mode_in,
  input  wire logic [27:0]             raw_segments_in,
  input  wire logic [3:0]              digit_blank_in,
  input  wire logic [3:0]              point_on_in,
  output logic      [NUM_BUTTONS-1:0]  button_pressed_out,
  output logic      [NUM_SWITCHES-1:0] switch_level_out,
  output logic      [NUM_LEDS-1:0]     led_out,
  output logic      [3:0]              digit_select_n_out,
  output logic      [6:0]              segment_line_n_out,
  output logic                         decimal_point_n_out
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  localparam int unsigned SLOT_MIN = (ssd_pkg::REFRESH_MIN_US / 1_000) * (ssd_pkg::CLK_HZ / 1_000) / 4;
  // Longest slot that still keeps the whole scan within 16 ms
  localparam int unsigned SLOT_MAX = (ssd_pkg::REFRESH_MAX_US / 1_000) * (ssd_pkg::CLK_HZ / 1_000) / 4;
  localparam int unsigned CNT_W    = $clog2(SLOT_MAX + 1);

  generate
    if (NUM_BUTTONS < 1 || NUM_SWITCHES < 1 || NUM_LEDS < 1) begin : g_bad_width
      $error("ssd_scan_io: I/O counts must be at least 1");
    end
    if (SLOT_CYC < 1 || SLOT_CYC > SLOT_MAX) begin : g_bad_slot
      $error("ssd_scan_io: SLOT_CYC outside range a counter can serve");
    end
    if (ssd_pkg::NUM_DIGITS != 4) begin : g_bad_digits
      $error("ssd_scan_io: select and segment ports are sized for four digits");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Segment decode
  // ---------------------------------------------------------------
  // Bit order {g,f,e,d,c,b,a}, active low
  function automatic logic [6:0] hex_to_seg_n(input logic [3:0] nib);
    logic [6:0] s;
    s = ssd_pkg::SEG_OFF;
    case (nib)
      4'h0:    s = 7'h40;
      4'h1:    s = ssd_pkg::SEG_ONE_N;
      4'h2:    s = 7'h24;
      4'h3:    s = 7'h30;
      4'h4:    s = 7'h19;
      4'h5:    s = 7'h12;
      4'h6:    s = 7'h02;
      4'h7:    s = 7'h78;
      4'h8:    s = 7'h00;
      4'h9:    s = 7'h10;
      4'hA:    s = 7'h08;
      4'hB:    s = 7'h03;
      4'hC:    s = 7'h46;
      4'hD:    s = 7'h21;
      4'hE:    s = 7'h06;
      4'hF:    s = 7'h0E;
      default: s = ssd_pkg::SEG_OFF;
    endcase
    return s;
  endfunction : hex_to_seg_n

  // Active-low one-hot select for a digit index
  function automatic logic [3:0] digit_sel_n(input logic [1:0] idx);
    return ~(4'h1 << idx);
  endfunction : digit_sel_n

  // Pattern of one digit: raw segments or hex font
  function automatic logic [6:0] digit_pattern(
    input logic [1:0]  idx,
    input logic [3:0]  raw_mode,
    input logic [27:0] raw_seg,
    input logic [15:0] hex
  );
    logic [6:0] p;
    if (raw_mode[idx]) begin
      p = raw_seg[idx*7 +: 7];
    end else begin
      p = hex_to_seg_n(hex[idx*4 +: 4]);
    end
    return p;
  endfunction : digit_pattern

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [NUM_BUTTONS-1:0]  button_sync;
  logic [NUM_SWITCHES-1:0] switch_sync;

  ssd_sync #(.WIDTH(NUM_BUTTONS + NUM_SWITCHES)) u_sync (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .async_in  ({button_in, switch_in}),
    .sync_out  ({button_sync, switch_sync})
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    ssd_pkg::ssd_state_t      mode;
    logic [CNT_W-1:0]         slot_cnt;
    logic [1:0]               digit;
    logic [NUM_BUTTONS-1:0]   buttons;
    logic [NUM_SWITCHES-1:0]  switches;
    logic [NUM_LEDS-1:0]      leds;
    logic [3:0]               sel_n;
    logic [6:0]               seg_n;
    logic                     dp_n;
  } ssd_state_s_t;

  ssd_state_s_t state_r;
  ssd_state_s_t state_nxt;

  // Value held during reset: display dark, inputs read as released
  localparam ssd_state_s_t RST_STATE = '{
    mode:     ssd_pkg::SSD_BLANK,
    slot_cnt: '0,
    digit:    2'h0,
    buttons:  '0,
    switches: '0,
    leds:     '0,
    sel_n:    ssd_pkg::SEL_OFF,
    seg_n:    ssd_pkg::SEG_OFF,
    dp_n:     1'b1
  };

  localparam logic [CNT_W-1:0] SLOT_LAST = CNT_W'(SLOT_CYC - 1);

  // Scan counter, digit rotation and next output pattern
  always_comb begin
    logic [1:0] dig;
    logic [6:0] pat;
    dig       = state_r.digit;
    pat       = ssd_pkg::SEG_OFF;
    state_nxt = state_r;

    state_nxt.buttons  = button_sync;
    state_nxt.switches = switch_sync;
    state_nxt.leds     = led_level_in;

    case (state_r.mode)
      ssd_pkg::SSD_BLANK: begin
        state_nxt.mode     = ssd_pkg::SSD_SCAN;
        state_nxt.slot_cnt = '0;
        dig                = 2'h0;
      end
      ssd_pkg::SSD_SCAN: begin
        if (state_r.slot_cnt == SLOT_LAST) begin
          state_nxt.slot_cnt = '0;
          dig                = state_r.digit + 2'h1;
        end else begin
          state_nxt.slot_cnt = state_r.slot_cnt + CNT_W'(1);
        end
      end
      default: begin
        state_nxt.mode = ssd_pkg::SSD_BLANK;
      end
    endcase
    state_nxt.digit = dig;

    // Pattern of the digit about to be selected, changed together with select
    pat = digit_pattern(dig, raw_mode_in, raw_segments_in, hex_value_in);

    if (state_nxt.mode == ssd_pkg::SSD_SCAN && !digit_blank_in[dig]) begin
      state_nxt.sel_n       = digit_sel_n(dig);
      state_nxt.seg_n       = pat;
      state_nxt.dp_n        = ~point_on_in[dig];
    end else begin
      state_nxt.sel_n = ssd_pkg::SEL_OFF;
      state_nxt.seg_n = ssd_pkg::SEG_OFF;
      state_nxt.dp_n  = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= RST_STATE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign button_pressed_out  = state_r.buttons;
  assign switch_level_out    = state_r.switches;
  assign led_out             = state_r.leds;
  assign digit_select_n_out  = state_r.sel_n;
  assign segment_line_n_out  = state_r.seg_n;
  assign decimal_point_n_out = state_r.dp_n;

endmodule : ssd_scan_io

// ---- tb/ssd_scan_io_monitor.sv ----
// Assertion checker for the seven-segment scan block
`timescale 1ns/10ps
module ssd_scan_io_monitor #(
  parameter int unsigned NUM_BUTTONS  = 5,
  parameter int unsigned NUM_SWITCHES = 16,
  parameter int unsigned NUM_LEDS     = 16,
  parameter int unsigned SLOT_CYC     = 8
) (
  input logic                    mclk_in,
  input logic                    resetn_in,
  input logic [NUM_BUTTONS-1:0]  button_in,
  input logic [NUM_SWITCHES-1:0] switch_in,
  input logic [NUM_LEDS-1:0]     led_level_in,
  input logic [3:0]              raw_mode_in,
  input logic [27:0]             raw_segments_in,
  input logic [3:0]              point_on_in,
  input logic [NUM_BUTTONS-1:0]  button_pressed_out,
  input logic [NUM_SWITCHES-1:0] switch_level_out,
  input logic [NUM_LEDS-1:0]     led_out,
  input logic [3:0]              digit_select_n_out,
  input logic [6:0]              segment_line_n_out,
  input logic                    decimal_point_n_out
);
  logic [2:0]  age_r;
  logic [3:0]  prev_r;
  int unsigned run_r;
  logic [1:0]  idx;
  always_comb begin
    case (digit_select_n_out)
      4'hD:    idx = 2'h1;
      4'hB:    idx = 2'h2;
      4'h7:    idx = 2'h3;
      default: idx = 2'h0;
    endcase
  end
  wire logic [6:0] pat      = raw_segments_in[7*idx +: 7];
  wire logic       mode_bit = raw_mode_in[idx];
  wire logic       pt_bit   = point_on_in[idx];
  // Age since release and length of the current slot
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      age_r  <= 3'h0;
      prev_r <= 4'hF;
      run_r  <= 0;
    end else begin
      age_r  <= (age_r == 3'h7) ? age_r : age_r + 3'h1;
      prev_r <= digit_select_n_out;
      run_r  <= (digit_select_n_out != prev_r) ? 0 : run_r + 1;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_slot_edge;
    $changed(digit_select_n_out) && age_r > 3'h1;
  endsequence
  sequence s_steady_digit;
    $stable(digit_select_n_out) && digit_select_n_out != 4'hF && age_r > 3'h1;
  endsequence
  a_led_follow: assert property (
    age_r != 3'h0 |-> led_out == $past(led_level_in)) else $error("led lag");
  a_button_sync: assert property (
    age_r >= 3'h3 |-> button_pressed_out == $past(button_in, 3)) else $error("button sync");
  a_switch_sync: assert property (
    age_r >= 3'h3 |-> switch_level_out == $past(switch_in, 3)) else $error("switch sync");
  a_one_digit: assert property ($onehot0(~digit_select_n_out)) else $error("two digits");
  a_first_digit: assert property (
    age_r == 3'h1 |-> digit_select_n_out == 4'hE) else $error("first digit");
  a_slot_length: assert property (run_r < SLOT_CYC) else $error("slot too long");
  a_slot_change: assert property (
    s_slot_edge |-> run_r == SLOT_CYC - 1) else $error("slot length");
  a_digit_rotate: assert property (
    s_slot_edge ##0 (prev_r != 4'hF && digit_select_n_out != 4'hF)
    |-> digit_select_n_out == {prev_r[2:0], prev_r[3]}) else $error("digit order");
  a_raw_hold: assert property (
    s_steady_digit ##0 $past(mode_bit) |-> segment_line_n_out == $past(pat)) else $error("segments");
  a_blank_dark: assert property (
    digit_select_n_out == 4'hF |-> segment_line_n_out == 7'h7F && decimal_point_n_out) else $error("blank lit");
  a_point_drive: assert property (
    s_steady_digit |-> decimal_point_n_out == !$past(pt_bit)) else $error("point");
endmodule : ssd_scan_io_monitor
bind ssd_scan_io ssd_scan_io_monitor #(.NUM_BUTTONS(NUM_BUTTONS), .NUM_SWITCHES(NUM_SWITCHES),
  .NUM_LEDS(NUM_LEDS), .SLOT_CYC(SLOT_CYC)) u_mon (.*);

// ---- tb/ssd_panel_model.sv ----
// Model of the panel pushbuttons and slide switches
`timescale 1ns/10ps
module ssd_panel_model (
  input  logic [4:0]  press_in,
  input  logic [15:0] slide_in,
  output logic [4:0]  button_out,
  output logic [15:0] switch_out
);
  assign button_out = press_in;
  assign switch_out = slide_in;
endmodule : ssd_panel_model

// ---- tb/ssd_scan_io_tb.sv ----
// Self-checking bench for the seven-segment scan block
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module ssd_scan_io_tb;
  localparam int S = 8;
  logic        mclk_in, resetn_in, dp;
  logic [4:0]  press, btn_pin;
  logic [15:0] slide, sw_pin, led_lv, hex;
  logic [3:0]  mode, blank, point, sel, hsel;
  logic [27:0] raws;
  logic [6:0]  seg;
  logic [11:0] e;
  logic [11:0] exp_q[$];
  int          num_errors = 0, num_checks = 0, since = 0, tick = 0;
  integer      seed;
  ssd_panel_model u_panel (.press_in(press), .slide_in(slide), .button_out(btn_pin), .switch_out(sw_pin));
  ssd_scan_io #(.SLOT_CYC(S)) u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .button_in(btn_pin),
    .switch_in(sw_pin), .led_level_in(led_lv), .hex_value_in(hex), .raw_mode_in(mode),
    .raw_segments_in(raws), .digit_blank_in(blank), .point_on_in(point), .button_pressed_out(),
    .switch_level_out(), .led_out(), .digit_select_n_out(sel), .segment_line_n_out(seg),
    .decimal_point_n_out(dp));
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  // New display inputs and the four slots they should produce
  task automatic new_round;
    {press, slide, led_lv} = 37'({$random(seed), $random(seed)});
    mode  = 4'($random(seed));
    blank = 4'($random(seed)) & 4'($random(seed)) & 4'hA;
    point = 4'($random(seed));
    raws  = 28'($random(seed));
    hsel  = 4'($random(seed));
    // Hex digits are a one (segments B and C lit) or an eight (all seven segments lit)
    for (int d = 0; d < 4; d++) begin
      hex[4*d +: 4] = hsel[d] ? 4'h8 : 4'h1;
      exp_q.push_back({blank[d] ? 4'hF : ~(4'h1 << d), mode[d] ? raws[7*d +: 7] :
        (hsel[d] ? 7'h00 : ssd_pkg::SEG_ONE_N), ~point[d]});
    end
  endtask : new_round
  initial begin
    mclk_in = 0;
    forever #4 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    tick  <= tick + 1;
    since <= resetn_in ? since + 1 : 0;
    if (tick == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  // Compare each slot as it starts
  always @(negedge mclk_in) begin
    if (since > 0 && (since - 1) % S == 0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      `CHK(sel, e[11:8])
      if (e[11:8] != 4'hF) begin
        `CHK(seg, e[7:1])
        `CHK(dp, e[0])
      end else begin
        `CHK(seg, ssd_pkg::SEG_OFF)
        `CHK(dp, 1'b1)
      end
    end
  end
  initial begin
    seed = 32'h488ba225;
    resetn_in = 0;
    new_round();
    repeat (12) @(posedge mclk_in);
    @(negedge mclk_in);
    resetn_in = 1;
    repeat (30) begin
      do @(negedge mclk_in); while ((since - 1) % (4 * S) != 4 * S - 1);
      new_round();
    end
    wait (exp_q.size() == 0);
    @(negedge mclk_in);
    end_of_test();
  end
endmodule : ssd_scan_io_tb
